// ===== shared/serirq_pkg.sv
// serirq_pkg: constants, states and slot decoding for the serialized
// interrupt link; assumes both ends and the bench import it whole

package serirq_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int         CLK_PERIOD_NS  = 50;
  localparam int         LCLK_PERIOD_NS = 400;
  localparam int         LCLK_HALF      = LCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam logic [2:0] LCLK_HALF_M1   = 3'(LCLK_HALF - 1);

  // ----------------------------------------------------------------
  // frame widths, counted in link clocks
  // ----------------------------------------------------------------
  localparam logic [3:0] START_MIN  = 4'h4;
  localparam logic [3:0] START_MAX  = 4'h8;
  localparam logic [3:0] STOP_QUIET = 4'h2;
  localparam logic [3:0] STOP_CONT  = 4'h3;
  localparam logic [3:0] CNT_SAT    = 4'hF;
  localparam logic       RESET_QUIET = 1'b0;

  // ----------------------------------------------------------------
  // slot layout
  // ----------------------------------------------------------------
  localparam logic [6:0] SLOT_BASE  = 7'h02;
  localparam logic [6:0] SLOT_STEP  = 7'h03;
  localparam int         NUM_FRAMES = 32;
  localparam logic [6:0] FRAME_END  = 7'(SLOT_BASE + SLOT_STEP * NUM_FRAMES);
  localparam logic [6:0] CYC_LAST   = 7'h7F;
  localparam int         NUM_SRC    = 7;
  localparam logic [3:0] IRQ_LEVEL [NUM_SRC] = '{4'h3, 4'h4, 4'h5, 4'h7, 4'h9, 4'hA, 4'hB};

  typedef enum logic [2:0] {D_IDLE, D_QSTART, D_START, D_FRAMES, D_STOP} dev_state_e;
  typedef enum logic [2:0] {H_IDLE, H_START, H_START_HI, H_FRAMES, H_STOP, H_STOP_HI}
    host_state_e;

  // sample clock of level l, which sits in frame l+1
  function automatic logic [6:0] slot_clock(input logic [3:0] level);
    return 7'(SLOT_BASE + SLOT_STEP * {3'h0, level});
  endfunction

  function automatic logic is_sample(input logic [6:0] c);
    return (c >= SLOT_BASE) && (c < FRAME_END) && (7'((c - SLOT_BASE) % SLOT_STEP) == 7'h00);
  endfunction

  function automatic logic [4:0] frame_index(input logic [6:0] c);
    return 5'((c - SLOT_BASE) / SLOT_STEP);
  endfunction

endpackage

// ===== shared/serirq_if.sv
// serirq_if: the shared interrupt line and the link clock between
// the host end and one device end; assumes a pull-up on the line

`timescale 1ns/1ps
`default_nettype none

interface serirq_if;
  logic lclk;
  logic host_o;
  logic host_oe;
  logic dev_o;
  logic dev_oe;
  logic line;

  // any driver pulling low wins, otherwise the pull-up holds it high
  assign line = ~((host_oe & ~host_o) | (dev_oe & ~dev_o));

  modport host   (output lclk, host_o, host_oe, input line);
  modport device (input lclk, line, output dev_o, dev_oe);
endinterface

`default_nettype wire

// ===== src/serirq_sync.sv
// serirq_sync: two-stage synchroniser for levels from another domain
// assumes d is asynchronous to clk_sys

`timescale 1ns/1ps
`default_nettype none

module serirq_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_sys,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic [W-1:0]      q
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] out;
  } sync_s;

  sync_s st;
  sync_s next_st;

  always_comb begin
    next_st.meta = d;
    next_st.out  = st.meta;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign q = st.out;

endmodule // serirq_sync

`default_nettype wire

// ===== src/serirq_host.sv
// serirq_host: controller end of the serialized interrupt line
// makes the link clock by dividing clk_sys; the line comes back
// through the interface and is synchronised before use

`timescale 1ns/1ps
`default_nettype none

module serirq_host
  import serirq_pkg::*;
(
  input  wire logic          clk_sys,
  input  wire logic          rst,
  serirq_if.host             bus,
  input  wire logic          cycle_req,
  input  wire logic          stop_quiet,
  output logic [NUM_FRAMES-1:0] irq_seen,
  output logic               quiet_mode,
  output logic               busy,
  output logic               cycle_done
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    host_state_e           state;
    logic [2:0]            div;
    logic                  lclk;
    logic                  quiet;
    logic [6:0]            cyc;
    logic [3:0]            cnt;
    logic [3:0]            stop_len;
    logic [NUM_FRAMES-1:0] seen;
    logic                  drv_o;
    logic                  drv_oe;
    logic                  busy;
    logic                  done;
  } host_s;

  host_s st;
  host_s next_st;
  logic  line_s;
  logic  rise;

  serirq_sync #(.W(1)) u_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .d       (bus.line),
    .q       (line_s)
  );

  assign rise = (st.div == LCLK_HALF_M1) && !st.lclk;

  // ----------------------------------------------------------------
  // cycle sequencer, stepped on each rising link clock
  // ----------------------------------------------------------------
  always_comb begin
    next_st      = st;
    next_st.done = 1'b0;
    if (st.div == LCLK_HALF_M1) begin
      next_st.div  = 3'h0;
      next_st.lclk = ~st.lclk;
    end else begin
      next_st.div = st.div + 3'h1;
    end
    if (rise) begin
      unique case (st.state)
        H_IDLE: begin
          next_st.drv_oe = 1'b0;
          if (cycle_req) begin
            next_st.state  = H_START;
            next_st.drv_o  = 1'b0;
            next_st.drv_oe = 1'b1;
            next_st.cnt    = 4'h1;
          end else if (st.quiet && !line_s) begin
            next_st.state  = H_START;
            next_st.drv_o  = 1'b0;
            next_st.drv_oe = 1'b1;
            next_st.cnt    = 4'h2;
          end
        end
        H_START: begin
          if (st.cnt < START_MIN) begin
            next_st.cnt = st.cnt + 4'h1;
          end else begin
            next_st.state = H_START_HI;
            next_st.drv_o = 1'b1;
          end
        end
        H_START_HI: begin
          next_st.drv_oe = 1'b0;
          next_st.cyc    = 7'h01;
          next_st.state  = H_FRAMES;
        end
        H_FRAMES: begin
          if (is_sample(st.cyc)) begin
            next_st.seen[frame_index(st.cyc)] = !line_s;
          end
          next_st.cyc = st.cyc + 7'h01;
          if (next_st.cyc == FRAME_END) begin
            next_st.state    = H_STOP;
            next_st.drv_o    = 1'b0;
            next_st.drv_oe   = 1'b1;
            next_st.cnt      = 4'h1;
            next_st.stop_len = stop_quiet ? STOP_QUIET : STOP_CONT;
          end
        end
        H_STOP: begin
          if (st.cnt < st.stop_len) begin
            next_st.cnt = st.cnt + 4'h1;
          end else begin
            next_st.state = H_STOP_HI;
            next_st.drv_o = 1'b1;
            next_st.quiet = (st.stop_len == STOP_QUIET);
          end
        end
        H_STOP_HI: begin
          next_st.drv_oe = 1'b0;
          next_st.state  = H_IDLE;
          next_st.done   = 1'b1;
        end
      endcase
      next_st.busy = (next_st.state != H_IDLE);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st <= '{state: H_IDLE, quiet: RESET_QUIET, drv_o: 1'b1, default: '0};
    end else begin
      st <= next_st;
    end
  end

  assign bus.lclk    = st.lclk;
  assign bus.host_o  = st.drv_o;
  assign bus.host_oe = st.drv_oe;
  assign irq_seen    = st.seen;
  assign quiet_mode  = st.quiet;
  assign busy        = st.busy;
  assign cycle_done  = st.done;

endmodule // serirq_host

`default_nettype wire

// ===== src/serirq_device.sv
// serirq_device: peripheral end of the serialized interrupt line
// assumes bus.lclk and bus.line are asynchronous to clk_sys and that
// irq_req comes from logic on clk_sys

`timescale 1ns/1ps
`default_nettype none

// Contract
// - start frame holds line low 4 to 8
// - continuous mode: only host opens start frames
// - reset leaves link in continuous mode
// - quiet mode: device pulls low one clock
// - host then extends low to 4-8 total
// - host drives high one clock, then releases
// - no start frame while a cycle runs
// - count frames on rising link clock edges
// - each frame: sample, recovery, turn-around
// - sample phase: low if active, else released
// - recovery drives high, turn-around releases
// - sources only on levels 3,4,5,7,9,10,11
// - frame n sampled 2+3(n-1) clocks in
// - host alone ends cycle with stop frame
// - stop width 2 quiet, 3 continuous
// - line released whenever no cycle runs
module serirq_device
  import serirq_pkg::*;
(
  input  wire logic               clk_sys,
  input  wire logic               rst,
  serirq_if.device                bus,
  input  wire logic [NUM_SRC-1:0] irq_req,
  output logic [NUM_SRC-1:0]      irq_reported,
  output logic                    quiet_mode,
  output logic                    busy,
  output logic                    cycle_done,
  output logic                    proto_err
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    dev_state_e         state;
    logic               mode_quiet;
    logic               clk_prev;
    logic               line_prev;
    logic [6:0]         cyc;
    logic [3:0]         cnt;
    logic [NUM_SRC-1:0] sent;
    logic               drv_o;
    logic               drv_oe;
    logic               busy;
    logic               done;
    logic               err;
  } dev_s;

  dev_s       st;
  dev_s       next_st;
  logic [1:0] sync_q;
  logic       clk_s;
  logic       line_s;
  logic       tick;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic start_len_ok(input logic [3:0] n);
    return (n >= START_MIN) && (n <= START_MAX);
  endfunction

  function automatic logic stop_len_ok(input logic [3:0] n);
    return (n == STOP_QUIET) || (n == STOP_CONT);
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers and link clock edge
  // ----------------------------------------------------------------
  serirq_sync #(.W(2)) u_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .d       ({bus.lclk, ~bus.line}),
    .q       (sync_q)
  );

  // the line is carried inverted so that reset leaves it at its idle
  // high level and no false start frame follows reset
  assign clk_s  = sync_q[1];
  assign line_s = ~sync_q[0];

  // line_prev holds the level from just before the edge, which is the
  // level of the link clock that is ending
  assign tick = clk_s & ~st.clk_prev;

  // ----------------------------------------------------------------
  // cycle tracker, stepped on each rising link clock
  // ----------------------------------------------------------------
  always_comb begin
    logic [6:0] slot;
    slot              = 7'h00;
    next_st           = st;
    next_st.clk_prev  = clk_s;
    next_st.line_prev = line_s;
    next_st.done      = 1'b0;
    next_st.err       = 1'b0;
    if (tick) begin
      unique case (st.state)
        D_IDLE: begin
          next_st.drv_oe = 1'b0;
          if (!st.line_prev) begin
            next_st.state = D_START;
            next_st.cnt   = 4'h1;
          end else if (st.mode_quiet && (irq_req != st.sent)) begin
            next_st.state  = D_QSTART;
            next_st.drv_o  = 1'b0;
            next_st.drv_oe = 1'b1;
            next_st.cnt    = 4'h1;
          end
        end
        D_QSTART: begin
          // own low clock is already counted; the host carries on
          next_st.drv_oe = 1'b0;
          next_st.state  = D_START;
        end
        D_START: begin
          if (!st.line_prev) begin
            if (st.cnt == START_MAX) begin
              next_st.err   = 1'b1;
              next_st.state = D_IDLE;
            end else begin
              next_st.cnt = st.cnt + 4'h1;
            end
          end else if (start_len_ok(st.cnt)) begin
            // the high clock that closes the start frame was clock 0
            next_st.state = D_FRAMES;
            next_st.cyc   = 7'h01;
          end else begin
            next_st.err   = 1'b1;
            next_st.state = D_IDLE;
          end
        end
        D_FRAMES: begin
          next_st.cyc    = st.cyc + 7'h01;
          next_st.drv_o  = 1'b1;
          next_st.drv_oe = 1'b0;
          if ((st.cyc >= FRAME_END) && !st.line_prev) begin
            next_st.state = D_STOP;
            next_st.cnt   = 4'h1;
          end else if (st.cyc == CYC_LAST) begin
            next_st.err   = 1'b1;
            next_st.state = D_IDLE;
          end else begin
            for (int i = 0; i < NUM_SRC; i++) begin
              slot = slot_clock(IRQ_LEVEL[i]);
              if (next_st.cyc == slot) begin
                if (irq_req[i]) begin
                  next_st.drv_o  = 1'b0;
                  next_st.drv_oe = 1'b1;
                end
                next_st.sent[i] = irq_req[i];
              end else if (next_st.cyc == 7'(slot + 7'h01)) begin
                next_st.drv_o  = 1'b1;
                next_st.drv_oe = 1'b1;
              end
            end
          end
        end
        D_STOP: begin
          if (!st.line_prev) begin
            if (st.cnt != CNT_SAT) begin
              next_st.cnt = st.cnt + 4'h1;
            end
          end else begin
            // any width other than the quiet one falls back to continuous
            next_st.mode_quiet = (st.cnt == STOP_QUIET);
            next_st.err        = !stop_len_ok(st.cnt);
            next_st.done       = 1'b1;
            next_st.state      = D_IDLE;
          end
        end
      endcase
      next_st.busy = (next_st.state != D_IDLE);
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st <= '{state: D_IDLE, mode_quiet: RESET_QUIET, drv_o: 1'b1, line_prev: 1'b1,
              default: '0};
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign bus.dev_o    = st.drv_o;
  assign bus.dev_oe   = st.drv_oe;
  assign irq_reported = st.sent;
  assign quiet_mode   = st.mode_quiet;
  assign busy         = st.busy;
  assign cycle_done   = st.done;
  assign proto_err    = st.err;

endmodule // serirq_device

`default_nettype wire

// ===== bench/serirq_link_checker.sv
// serirq_link_checker: timing checks on the shared line and the link clock
// assumes it sits beside the interface that joins the host and device ends
`timescale 1ns/1ps
`default_nettype none
module serirq_link_checker (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic lclk,
  input wire logic host_o,
  input wire logic host_oe,
  input wire logic dev_o,
  input wire logic dev_oe,
  input wire logic line
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  logic       hlow;
  logic       hhigh;
  logic       dlow;
  logic       dhigh;
  logic [5:0] run;

  assign hlow  = host_oe & ~host_o;
  assign hhigh = host_oe & host_o;
  assign dlow  = dev_oe & ~dev_o;
  assign dhigh = dev_oe & dev_o;

  // ----------------------------------------------------------------
  // length of the running host low drive, in clk_sys cycles
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      run <= 6'h00;
    end else begin
      run <= hlow ? run + 6'h01 : 6'h00;
    end
  end

  AST_HOST_LOW_LEN: assert property ($fell(hlow) |-> run inside {6'h10, 6'h18, 6'h20})
    else $error("host low drive of wrong length");
  AST_HOST_HIGH_ONE: assert property ($rose(hhigh) |-> hhigh[*8] ##1 !host_oe)
    else $error("host high drive not one link clock then released");
  AST_HOST_ON_LCLK: assert property ($rose(hlow) |-> $rose(lclk))
    else $error("host low drive not begun with a link clock rise");
  AST_LCLK_DIV: assert property ($rose(lclk) |-> lclk[*4] ##1 (!lclk)[*4] ##1 lclk)
    else $error("link clock period wrong");
  AST_DEV_LOW_ONE: assert property ($rose(dlow) |-> dlow[*8] ##1 !dlow)
    else $error("device low drive not one link clock");
  AST_DEV_RECOVER: assert property (dlow ##1 dhigh |-> dhigh[*8] ##1 !dev_oe)
    else $error("device recovery not one high clock then released");
  AST_DEV_ON_LCLK: assert property ($rose(dlow) |-> $past(lclk, 3) && !$past(lclk, 4))
    else $error("device low drive off the link clock phase");
  AST_QUIET_AFTER_HIGH: assert property ($fell(hhigh) |-> (!dev_oe)[*8])
    else $error("device drives right after host high clock");
  AST_NO_FIGHT: assert property (!(hhigh && dlow))
    else $error("host high and device low at once");

  cover property ($fell(hlow) && run == 6'h10);
  cover property ($fell(hlow) && run == 6'h18);
  cover property (dlow && !line ##8 dhigh);
endmodule // serirq_link_checker
`default_nettype wire

// ===== bench/serial_irq_agent_test.sv
// serial_irq_agent_test: host and device ends joined over the link, plus
// a lone device end facing a bench driver that breaks the start width
// assumes the package, interface, both ends and the checker compile first
`timescale 1ns/1ps
`default_nettype none
module serial_irq_agent_test import serirq_pkg::*;;
  logic                  clk_sys;
  logic                  rst;
  logic                  cycle_req;
  logic                  stop_quiet;
  logic [NUM_SRC-1:0]    irq_req;
  logic [NUM_SRC-1:0]    irq_rep;
  logic [NUM_SRC-1:0]    nreq;
  logic [NUM_SRC-1:0]    last;
  logic [NUM_FRAMES-1:0] irq_seen;
  logic                  h_quiet, h_busy, h_done;
  logic                  d_quiet, d_busy, d_done, d_err, b_err;
  logic                  err_seen, berr_seen, done_seen, qm, sq;
  int                    bad_count, check_count, n;

  serirq_if bus ();
  serirq_if bad ();

  serirq_host u_serirq_host (.clk_sys, .rst, .bus(bus), .cycle_req, .stop_quiet, .irq_seen,
    .quiet_mode(h_quiet), .busy(h_busy), .cycle_done(h_done));
  serirq_device u_serirq_device (.clk_sys, .rst, .bus(bus), .irq_req, .irq_reported(irq_rep),
    .quiet_mode(d_quiet), .busy(d_busy), .cycle_done(d_done), .proto_err(d_err));
  serirq_device u_serirq_device_b (.clk_sys, .rst, .bus(bad), .irq_req(7'h00),
    .irq_reported(), .quiet_mode(), .busy(), .cycle_done(), .proto_err(b_err));
  serirq_link_checker u_serirq_link_checker (.clk_sys, .rst, .lclk(bus.lclk),
    .host_o(bus.host_o), .host_oe(bus.host_oe), .dev_o(bus.dev_o), .dev_oe(bus.dev_oe),
    .line(bus.line));

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  always @(negedge clk_sys) begin
    if (d_err === 1'b1) err_seen = 1'b1;
    if (b_err === 1'b1) berr_seen = 1'b1;
    if (d_done === 1'b1) done_seen = 1'b1;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tally_and_finish();
    if (bad_count == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // only the device's seven levels may ever show up as low samples
  function automatic logic [31:0] exp_seen(input logic [NUM_SRC-1:0] r);
    logic [31:0] e;
    e = 32'h0;
    for (int i = 0; i < NUM_SRC; i++) e[IRQ_LEVEL[i]] = r[i];
    return e;
  endfunction

  task automatic wait_done();
    n = 0;
    while (h_done !== 1'b1 && n < 2000) begin
      @(negedge clk_sys);
      n++;
    end
    chk("host cycle end", 32'h1, 32'(h_done));
    repeat (16) @(negedge clk_sys);
  endtask

  // one bench-made link clock per step; it stands still between calls
  task automatic lk(input logic oe, input logic v, input int cnt);
    repeat (cnt) begin
      bad.host_oe = oe;
      bad.host_o  = v;
      repeat (LCLK_HALF) @(negedge clk_sys);
      bad.lclk = 1'b1;
      repeat (LCLK_HALF) @(negedge clk_sys);
      bad.lclk = 1'b0;
    end
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    cycle_req = 1'b0;
    stop_quiet = 1'b0;
    irq_req = 7'h00;
    last = 7'h00;
    bad.lclk = 1'b0;
    bad.host_o = 1'b1;
    bad.host_oe = 1'b0;
    bad_count = 0;
    check_count = 0;
    err_seen = 1'b0;
    berr_seen = 1'b0;
    qm = 1'b0;
    void'($urandom(32'hA89B));
    repeat (2) @(negedge clk_sys);
    rst = 1'b0;
    chk("device mode after reset", 32'h0, 32'(d_quiet));
    for (int k = 0; k < 8; k++) begin
      nreq = (k == 0) ? 7'h7F : (k < 3) ? 7'h00 : 7'($urandom);
      sq = (k < 3) ? 1'b1 : 1'($urandom);
      stop_quiet = sq;
      irq_req = nreq;
      done_seen = 1'b0;
      if (!(qm && nreq != last)) begin
        repeat (192) @(negedge clk_sys);
        chk("no start while waiting", 32'h0, 32'({h_busy, d_busy}));
        cycle_req = 1'b1;
        n = 0;
        while (h_busy !== 1'b1 && n < 40) begin
          @(negedge clk_sys);
          n++;
        end
        cycle_req = 1'b0;
      end
      wait_done();
      chk("irq_seen", exp_seen(nreq), irq_seen);
      chk("irq_reported", 32'(nreq), 32'(irq_rep));
      chk("host mode", 32'(sq), 32'(h_quiet));
      chk("device mode", 32'(sq), 32'(d_quiet));
      chk("device stop seen", 32'h1, 32'(done_seen));
      chk("device error", 32'h0, 32'(err_seen));
      qm = sq;
      last = nreq;
    end
    for (int w = 3; w <= 9; w += 6) begin
      berr_seen = 1'b0;
      lk(1'b1, 1'b0, w);
      lk(1'b1, 1'b1, 1);
      lk(1'b0, 1'b1, 3);
      chk("bad start width error", 32'h1, 32'(berr_seen));
    end
    tally_and_finish();
  end

  // the tests need about 0.4 ms; this cuts a hang at 3 ms
  initial begin
    #3000000;
    bad_count++;
    tally_and_finish();
  end
endmodule // serial_irq_agent_test
`default_nettype wire
